// ==== verilog/startup_mode_select.sv ====
// power-up mode selector: eeprom probe, strap sample, vendor command gate
// Notes on behaviour
// - probe eeprom and sample ata reset strap before settling the mode
// - legacy signature found: legacy pinout and eeprom layout
// - normal signature found: descriptors from eeprom, normal operation
// - no eeprom answers: default ids, mode flagged not valid
// - eeprom with unknown signature: board manufacturing test mode
// - ata reset line low at power-up: board manufacturing test mode
// - normal mode: full bridge, descriptors from eeprom values
// - test mode: usb active, ata interface only partly active
// - test mode accepts eeprom access and board test vendor commands
// - eeprom access command recognised by byte 1 value 0x26
// - board test command: byte 1 value 0x27, bytes 2 to 15 zero
// - board test load keeps manufacturing test operation until hard reset
`timescale 1ns/1ps
`include "startup_consts.svh"

module startup_mode_select (
  input  wire logic         clk,                 // 25 MHz clock
  input  wire logic         sys_rst,             // async reset, high
  input  wire logic         scl_i,               // i2c clock pin level
  output logic              scl_o,               // i2c clock drive value
  output logic              scl_oe_n_q,          // low pulls clock low
  input  wire logic         sda_i,               // i2c data pin level
  output logic              sda_o,               // i2c data drive value
  output logic              sda_oe_n_q,          // low pulls data low
  input  wire logic         ata_reset_line_n,    // ata reset pin level
  input  wire logic         cb_valid,            // command block strobe
  input  wire logic         cb_dir_in,           // 1 read, 0 load
  input  wire logic [7:0]   cb_byte1,            // sub-command byte
  input  wire logic [111:0] cb_tail,             // bytes 2 to 15
  output startup_pkg::mode_e mode_q,             // selected mode
  output logic              mode_valid_q,        // mode is usable
  output logic              legacy_pinout_q,     // legacy pin/eeprom map
  output logic              desc_from_eeprom_q,  // descriptors from eeprom
  output logic              default_ids_q,       // built-in zero ids
  output logic              ata_full_q,          // ata fully active
  output logic              ata_partial_q,       // ata partly active
  output logic              usb_enum_en_q,       // enumeration allowed
  output logic [15:0]       signature_q,         // word read at start
  output logic              eeprom_access_block_q, // eeprom cmd pulse
  output logic              board_test_block_q,  // board test cmd pulse
  output logic              cb_reject_q,         // refused cmd pulse
  output logic              mfg_active_q         // manufacturing test held
);

  // clock line is never driven high; data driven low only
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;

  // two-stage synchronisers for the sda and ata reset pins
  logic sda_m_q, sda_s_q, ata_m_q, ata_s_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      ata_m_q <= 1'b1;
      ata_s_q <= 1'b1;
    end else begin
      sda_m_q <= sda_i;
      sda_s_q <= sda_m_q;
      ata_m_q <= ata_reset_line_n;
      ata_s_q <= ata_m_q;
    end
  end

  // probe sequencer state
  startup_pkg::state_e   state_q, state_d;
  logic [`QCNT_W-1:0]    cnt_q, cnt_d;
  logic [1:0]            ph_q, ph_d;
  logic [2:0]            bit_q, bit_d;
  logic [2:0]            step_q, step_d;
  logic [7:0]            shift_q, shift_d;
  logic [15:0]           sig_d;
  logic                  found_q, found_d;
  logic                  strap_q, strap_d;
  logic                  scl_oe_n_d, sda_oe_n_d;
  startup_pkg::mode_e    mode_d;
  logic                  done_d;
  logic                  tick, rd_step;

  assign tick    = (cnt_q == `QCNT_W'(`QUARTER_CYC - 1));
  assign rd_step = (step_q == `STEP_RD_HI) || (step_q == `STEP_RD_LO);

  // mode choice from strap, presence and signature
  function automatic startup_pkg::mode_e pick_mode(input logic strap_n,
                                                   input logic found,
                                                   input logic [15:0] sig);
    if (!strap_n)
      pick_mode = startup_pkg::MODE_TEST;
    else if (!found)
      pick_mode = startup_pkg::MODE_NOEE;
    else if (sig == `SIG_LEGACY)
      pick_mode = startup_pkg::MODE_LEGACY;
    else if (sig == `SIG_NORMAL)
      pick_mode = startup_pkg::MODE_NORMAL;
    else
      pick_mode = startup_pkg::MODE_TEST;
  endfunction : pick_mode

  // next state of the probe: start, bytes, acks, stop
  always_comb begin
    state_d    = state_q;
    cnt_d      = tick ? '0 : cnt_q + `QCNT_W'(1);
    ph_d       = tick ? ph_q + 2'd1 : ph_q;
    bit_d      = bit_q;
    step_d     = step_q;
    shift_d    = shift_q;
    sig_d      = signature_q;
    found_d    = found_q;
    strap_d    = strap_q;
    scl_oe_n_d = scl_oe_n_q;
    sda_oe_n_d = sda_oe_n_q;
    mode_d     = mode_q;
    done_d     = usb_enum_en_q;
    case (state_q)
      startup_pkg::S_INIT: begin
        ph_d = 2'd0;
        if (tick) begin
          strap_d = ata_s_q;
          shift_d = `EE_DEV_WR;
          state_d = startup_pkg::S_START;
        end
      end
      startup_pkg::S_START: begin
        if (tick) begin
          case (ph_q)
            2'd0: sda_oe_n_d = 1'b1;
            2'd1: scl_oe_n_d = 1'b1;
            2'd2: sda_oe_n_d = 1'b0;
            default: begin
              scl_oe_n_d = 1'b0;
              bit_d      = 3'd0;
              state_d    = startup_pkg::S_BIT;
            end
          endcase
        end
      end
      startup_pkg::S_BIT: begin
        if (tick) begin
          case (ph_q)
            2'd0: sda_oe_n_d = rd_step ? 1'b1 : shift_q[7];
            2'd1: scl_oe_n_d = 1'b1;
            2'd2: if (rd_step) shift_d = {shift_q[6:0], sda_s_q};
            default: begin
              scl_oe_n_d = 1'b0;
              if (!rd_step) shift_d = {shift_q[6:0], 1'b0};
              bit_d = bit_q + 3'd1;
              if (bit_q == 3'd7) state_d = startup_pkg::S_ACK;
            end
          endcase
        end
      end
      startup_pkg::S_ACK: begin
        if (tick) begin
          case (ph_q)
            2'd0: sda_oe_n_d = (step_q != `STEP_RD_HI);
            2'd1: scl_oe_n_d = 1'b1;
            2'd2: if (!rd_step && sda_s_q) found_d = 1'b0;
            default: begin
              scl_oe_n_d = 1'b0; // sda held; it moves only in phase 0
              step_d     = step_q + 3'd1;
              bit_d      = 3'd0;
              state_d    = startup_pkg::S_BIT;
              if (!found_q) begin
                state_d = startup_pkg::S_STOP;
              end else begin
                case (step_q)
                  `STEP_DEV_WR: shift_d = `EE_START_ADDR;
                  `STEP_ADDR: begin
                    shift_d = `EE_DEV_RD;
                    state_d = startup_pkg::S_START;
                  end
                  `STEP_RD_HI: sig_d[15:8] = shift_q;
                  `STEP_RD_LO: begin
                    sig_d[7:0] = shift_q;
                    state_d    = startup_pkg::S_STOP;
                  end
                  default: ;
                endcase
              end
            end
          endcase
        end
      end
      startup_pkg::S_STOP: begin
        if (tick) begin
          case (ph_q)
            2'd0: sda_oe_n_d = 1'b0;
            2'd1: scl_oe_n_d = 1'b1;
            2'd2: sda_oe_n_d = 1'b1;
            default: begin
              mode_d  = pick_mode(strap_q, found_q, signature_q);
              done_d  = 1'b1;
              state_d = startup_pkg::S_DONE;
            end
          endcase
        end
      end
      startup_pkg::S_DONE: begin
        cnt_d = '0;
        ph_d  = 2'd0;
      end
      default: state_d = startup_pkg::S_INIT;
    endcase
  end

  // vendor command gate, only in test mode
  logic acc_hit, test_hit, in_test;
  logic acc_d, test_d, rej_d, mfg_d;
  always_comb begin
    in_test  = usb_enum_en_q && (mode_q == startup_pkg::MODE_TEST);
    acc_hit  = (cb_byte1 == `SUB_EEPROM_ACC);
    test_hit = (cb_byte1 == `SUB_BOARD_TEST) && (cb_tail == '0);
    acc_d    = cb_valid && in_test && acc_hit;
    test_d   = cb_valid && in_test && test_hit;
    rej_d    = cb_valid && !(in_test && (acc_hit || test_hit));
    mfg_d    = mfg_active_q || (test_d && !cb_dir_in);
  end

  // registers of sequencer, decoded mode outputs and command gate
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q               <= startup_pkg::S_INIT;
      cnt_q                 <= '0;
      ph_q                  <= 2'd0;
      bit_q                 <= 3'd0;
      step_q                <= `STEP_DEV_WR;
      shift_q               <= 8'h00;
      signature_q           <= 16'h0000;
      found_q               <= 1'b1;
      strap_q               <= 1'b1;
      scl_oe_n_q            <= 1'b1;
      sda_oe_n_q            <= 1'b1;
      mode_q                <= startup_pkg::MODE_NOEE;
      usb_enum_en_q         <= 1'b0;
      mode_valid_q          <= 1'b0;
      legacy_pinout_q       <= 1'b0;
      desc_from_eeprom_q    <= 1'b0;
      default_ids_q         <= 1'b0;
      ata_full_q            <= 1'b0;
      ata_partial_q         <= 1'b0;
      eeprom_access_block_q <= 1'b0;
      board_test_block_q    <= 1'b0;
      cb_reject_q           <= 1'b0;
      mfg_active_q          <= 1'b0;
    end else begin
      state_q               <= state_d;
      cnt_q                 <= cnt_d;
      ph_q                  <= ph_d;
      bit_q                 <= bit_d;
      step_q                <= step_d;
      shift_q               <= shift_d;
      signature_q           <= sig_d;
      found_q               <= found_d;
      strap_q               <= strap_d;
      scl_oe_n_q            <= scl_oe_n_d;
      sda_oe_n_q            <= sda_oe_n_d;
      mode_q                <= mode_d;
      usb_enum_en_q         <= done_d;
      mode_valid_q          <= done_d && (mode_d != startup_pkg::MODE_NOEE);
      legacy_pinout_q       <= done_d && (mode_d == startup_pkg::MODE_LEGACY);
      desc_from_eeprom_q    <= done_d && (mode_d == startup_pkg::MODE_NORMAL ||
                               mode_d == startup_pkg::MODE_LEGACY);
      default_ids_q         <= done_d && (mode_d == startup_pkg::MODE_NOEE);
      ata_full_q            <= done_d && (mode_d != startup_pkg::MODE_TEST);
      ata_partial_q         <= done_d &&
                               (mode_d == startup_pkg::MODE_TEST);
      eeprom_access_block_q <= acc_d;
      board_test_block_q    <= test_d;
      cb_reject_q           <= rej_d;
      mfg_active_q          <= mfg_d;
    end
  end

endmodule : startup_mode_select

// ==== verilog/startup_consts.svh ====
// constants for the power-up mode selector
`ifndef STARTUP_CONSTS_SVH
`define STARTUP_CONSTS_SVH

// clock and i2c timing, times in ns
`define CLK_PERIOD_NS   40
`define I2C_QUARTER_NS  2500
// least time, rounded up to whole cycles
`define QUARTER_CYC     ((`I2C_QUARTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define QCNT_W          7

// eeprom bus addresses and start offset
`define EE_DEV_WR       8'hA0
`define EE_DEV_RD       8'hA1
`define EE_START_ADDR   8'h00

// signature words, first byte in the upper half
`define SIG_LEGACY      16'h4D4D
`define SIG_NORMAL      16'h534B

// vendor command sub-command codes
`define SUB_EEPROM_ACC  8'h26
`define SUB_BOARD_TEST  8'h27

// probe sequence steps
`define STEP_DEV_WR     3'h0
`define STEP_ADDR       3'h1
`define STEP_DEV_RD     3'h2
`define STEP_RD_HI      3'h3
`define STEP_RD_LO      3'h4

`endif

// ==== verilog/startup_pkg.sv ====
// types shared by the power-up mode selector
package startup_pkg;

  // operating modes, one-hot
  typedef enum logic [3:0] {
    MODE_LEGACY = 4'h1,
    MODE_NORMAL = 4'h2,
    MODE_NOEE   = 4'h4,
    MODE_TEST   = 4'h8
  } mode_e;

  // probe sequencer states, one-hot
  typedef enum logic [5:0] {
    S_INIT  = 6'h01,
    S_START = 6'h02,
    S_BIT   = 6'h04,
    S_ACK   = 6'h08,
    S_STOP  = 6'h10,
    S_DONE  = 6'h20
  } state_e;

endpackage : startup_pkg

// ==== tb/startup_mode_chk.sv ====
// port assertions for the power-up mode selector
`timescale 1ns/1ps
module startup_mode_chk (
  input wire logic               clk,                   // clock
  input wire logic               sys_rst,               // reset
  input wire logic               cb_valid,              // cmd strobe
  input wire logic               cb_dir_in,             // cmd direction
  input wire logic [7:0]         cb_byte1,              // sub-command
  input wire logic [111:0]       cb_tail,               // bytes 2..15
  input wire startup_pkg::mode_e mode_q,                // mode
  input wire logic               mode_valid_q,          // mode usable
  input wire logic               legacy_pinout_q,       // legacy map
  input wire logic               desc_from_eeprom_q,    // eeprom desc
  input wire logic               default_ids_q,         // zero ids
  input wire logic               ata_full_q,            // ata full
  input wire logic               ata_partial_q,         // ata partial
  input wire logic               usb_enum_en_q,         // enum allowed
  input wire logic [15:0]        signature_q,           // word read
  input wire logic               eeprom_access_block_q, // eeprom cmd
  input wire logic               board_test_block_q,    // board cmd
  input wire logic               cb_reject_q,           // refused
  input wire logic               mfg_active_q           // test held
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (sys_rst);
  // settled mode flags
  wire en = usb_enum_en_q;
  wire tm = en && mode_q == startup_pkg::MODE_TEST;
  wire lg = mode_q == startup_pkg::MODE_LEGACY;
  wire nm = mode_q == startup_pkg::MODE_NORMAL;
  wire ne = mode_q == startup_pkg::MODE_NOEE;

  a_no_early_mode: assert property (!en |->
    !(ata_full_q || ata_partial_q || mode_valid_q)) else $error("early mode");
  a_mode_held: assert property (en |=> en && $stable(mode_q))
    else $error("mode changed");
  a_noee_invalid: assert property (en && ne |->
    !mode_valid_q && default_ids_q) else $error("no eeprom flags");
  a_legacy_map: assert property (en |-> legacy_pinout_q == lg &&
    (!lg || signature_q == 16'h4D4D)) else $error("legacy map");
  a_normal_desc: assert property (en && nm |->
    desc_from_eeprom_q && signature_q == 16'h534B) else $error("normal");
  a_test_partial: assert property (en |-> ata_partial_q == tm &&
    ata_full_q != ata_partial_q) else $error("ata activity");
  a_one_answer: assert property (cb_valid |=> $onehot(
    {eeprom_access_block_q, board_test_block_q, cb_reject_q}))
    else $error("not one answer");
  a_gate_reject: assert property (cb_valid && !tm |=> cb_reject_q)
    else $error("gate open");
  a_ee_cmd: assert property (cb_valid && tm && cb_byte1 == 8'h26 |=>
    eeprom_access_block_q) else $error("eeprom cmd");
  a_board_load: assert property (cb_valid && tm && cb_byte1 == 8'h27 &&
    cb_tail == 112'h0 && !cb_dir_in |=> board_test_block_q && mfg_active_q)
    else $error("board cmd");
  a_mfg_sticky: assert property (mfg_active_q |=> mfg_active_q)
    else $error("test dropped");
endmodule : startup_mode_chk

bind startup_mode_select startup_mode_chk chk_u (
  .clk(clk), .sys_rst(sys_rst), .cb_valid(cb_valid), .cb_dir_in(cb_dir_in),
  .cb_byte1(cb_byte1), .cb_tail(cb_tail), .mode_q(mode_q),
  .mode_valid_q(mode_valid_q), .legacy_pinout_q(legacy_pinout_q),
  .desc_from_eeprom_q(desc_from_eeprom_q), .default_ids_q(default_ids_q),
  .ata_full_q(ata_full_q), .ata_partial_q(ata_partial_q),
  .usb_enum_en_q(usb_enum_en_q), .signature_q(signature_q),
  .eeprom_access_block_q(eeprom_access_block_q),
  .board_test_block_q(board_test_block_q), .cb_reject_q(cb_reject_q),
  .mfg_active_q(mfg_active_q)
);

// ==== tb/ee_model.sv ====
// serial eeprom model answering the start-up probe
`timescale 1ns/1ps
module ee_model (
  input  wire logic        scl,     // clock wire level
  input  wire logic        sda,     // data wire level
  input  wire logic        present, // 0 never acks
  input  wire logic [15:0] word,    // first two bytes
  output logic             pull_n   // low pulls data low
);
  int bitn = 0;
  int byten = 0;
  logic rd = 1'b0;
  logic mack = 1'b0;
  logic [7:0] sh = 8'h00;
  logic [7:0] tx = 8'hFF;
  initial pull_n = 1'b1;
  // start or stop: restart framing, let the line go
  always @(sda) if (scl) begin
    bitn = 0;
    byten = 0;
    rd = 1'b0;
    tx = 8'hFF;
    pull_n = 1'b1;
  end
  // shift in bits, note master ack
  always @(posedge scl) begin
    if (bitn < 8) sh = {sh[6:0], sda};
    else mack = !sda;
    bitn++;
  end
  // data changes only while the clock is low
  always @(negedge scl) begin
    if (bitn == 8) begin
      if (byten == 0) rd = (sh == 8'hA1);
      pull_n = !(present && !(rd && byten > 0));
    end else begin
      if (bitn == 9) begin
        bitn = 0;
        byten++;
        tx = !rd ? 8'hFF : byten == 1 ? word[15:8]
           : (mack && byten == 2) ? word[7:0] : 8'hFF;
      end
      pull_n = tx[7];
      tx = {tx[6:0], 1'b1};
    end
  end
endmodule : ee_model

// ==== tb/testbench.sv ====
// self-checking bench for the power-up mode selector
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic strap_n = 1'b1;
  logic present = 1'b1;
  logic [15:0] word = 16'h0000;
  logic cb_valid = 1'b0;
  logic cb_dir_in = 1'b0;
  logic [7:0] cb_byte1 = 8'h00;
  logic [111:0] cb_tail = 112'h0;
  logic scl_oe_n_q, sda_oe_n_q, scl_o, sda_o, pull_n, mfg_e;
  logic usb_enum_en_q, mode_valid_q, mfg_active_q;
  logic eeprom_access_block_q, board_test_block_q, cb_reject_q;
  logic [15:0] signature_q, w;
  startup_pkg::mode_e mode_q, cur_m;
  int bad_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  // open-drain wires with pull-ups
  wire sda_w = (sda_oe_n_q | sda_o) & pull_n;
  wire scl_w = scl_oe_n_q | scl_o;

  always #20 clk = ~clk;

  startup_mode_select dut_u (
    .clk(clk), .sys_rst(sys_rst), .scl_i(scl_w), .scl_o(scl_o),
    .scl_oe_n_q(scl_oe_n_q), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_n_q(sda_oe_n_q), .ata_reset_line_n(strap_n),
    .cb_valid(cb_valid), .cb_dir_in(cb_dir_in), .cb_byte1(cb_byte1),
    .cb_tail(cb_tail), .mode_q(mode_q), .mode_valid_q(mode_valid_q),
    .legacy_pinout_q(), .desc_from_eeprom_q(), .default_ids_q(),
    .ata_full_q(), .ata_partial_q(), .usb_enum_en_q(usb_enum_en_q),
    .signature_q(signature_q),
    .eeprom_access_block_q(eeprom_access_block_q),
    .board_test_block_q(board_test_block_q), .cb_reject_q(cb_reject_q),
    .mfg_active_q(mfg_active_q));
  ee_model ee_u (.scl(scl_w), .sda(sda_w), .present(present),
    .word(word), .pull_n(pull_n));

  // expected mode from probe result and strap
  function automatic startup_pkg::mode_e exp_mode(input logic p, input logic s,
                                                  input logic [15:0] v);
    if (!s) return startup_pkg::MODE_TEST;
    if (!p) return startup_pkg::MODE_NOEE;
    if (v == 16'h4D4D) return startup_pkg::MODE_LEGACY;
    if (v == 16'h534B) return startup_pkg::MODE_NORMAL;
    return startup_pkg::MODE_TEST;
  endfunction : exp_mode

  // expected answer pulses: eeprom, board, refused
  function automatic logic [2:0] exp_cmd(input logic [7:0] b,
                                         input logic [111:0] t);
    if (cur_m !== startup_pkg::MODE_TEST) return 3'b001;
    if (b == 8'h26) return 3'b100;
    return (b == 8'h27 && t == 112'h0) ? 3'b010 : 3'b001;
  endfunction : exp_cmd

  task automatic fail(input string m);
    bad_count++;
    $display("BAD %0t %s", $time, m);
  endtask : fail

  task automatic test_done;
    $display("compares %0d bad %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  // reset with given eeprom and strap, wait for the probe
  task automatic boot(input logic p, input logic s, input logic [15:0] v);
    int n;
    @(negedge clk);
    sys_rst = 1'b1;
    present = p;
    strap_n = s;
    word = v;
    cur_m = exp_mode(p, s, v);
    mfg_e = 1'b0;
    repeat (12) @(negedge clk);
    sys_rst = 1'b0;
    n = 0;
    while (usb_enum_en_q !== 1'b1 && n < 14000) begin
      @(negedge clk);
      n++;
    end
  endtask : boot

  task automatic chk_mode;
    samples_checked++;
    if (usb_enum_en_q !== 1'b1 || mode_q !== cur_m ||
        mode_valid_q !== (cur_m != startup_pkg::MODE_NOEE)) fail("mode");
  endtask : chk_mode

  task automatic chk_word(input logic [15:0] v);
    samples_checked++;
    if (signature_q !== v) fail("signature");
  endtask : chk_word

  // one command block, answer and test flag checked next cycle
  task automatic cmd(input logic [7:0] b, input logic [111:0] t,
                     input logic d);
    logic [2:0] e;
    e = exp_cmd(b, t);
    if (e == 3'b010 && !d) mfg_e = 1'b1;
    @(negedge clk);
    cb_valid = 1'b1;
    cb_byte1 = b;
    cb_tail = t;
    cb_dir_in = d;
    @(negedge clk);
    cb_valid = 1'b0;
    samples_checked++;
    if ({eeprom_access_block_q, board_test_block_q, cb_reject_q} !== e ||
        mfg_active_q !== mfg_e) fail("command answer");
  endtask : cmd

  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc > 75000) begin
      fail("timeout");
      test_done;
    end
  end

  initial begin
    void'($urandom(32'hF32C6513));
    boot(1'b1, 1'b1, 16'h4D4D);
    chk_mode;
    chk_word(16'h4D4D);
    cmd(8'h26, 112'h0, 1'b0);
    $display("legacy test done");
    boot(1'b1, 1'b1, 16'h534B);
    chk_mode;
    cmd(8'h27, 112'h0, 1'b0);
    $display("normal test done");
    boot(1'b0, 1'b1, 16'($urandom));
    chk_mode;
    $display("no eeprom test done");
    w = 16'($urandom) & 16'hFFFE;
    boot(1'b1, 1'b1, w);
    chk_mode;
    chk_word(w);
    cmd(8'h27, 112'h80 << 104, 1'b0);
    cmd(8'h27, 112'h1 << ($urandom % 112), 1'b0);
    cmd(8'h27, 112'h0, 1'b1);
    for (int i = 0; i < 24; i++) begin
      cmd(i % 3 == 0 ? 8'h26 : i % 3 == 1 ? 8'h27 : 8'($urandom),
          i % 2 == 0 ? 112'h0 : 112'({$urandom, $urandom, $urandom, $urandom}),
          1'($urandom));
    end
    cmd(8'h27, 112'h0, 1'b0);
    cmd(8'h26, 112'({$urandom, $urandom, $urandom, $urandom}), 1'b1);
    $display("bad signature test done");
    boot(1'b1, 1'b0, 16'h534B);
    chk_mode;
    cmd(8'h55, 112'h0, 1'b0);
    $display("strap test done");
    test_done;
  end
endmodule : testbench
